// ---- rtl/tospc_pkg.sv ----
// Constants, field positions and command codes of the output block.
// Assumes a 50 MHz core clock and a slow external serial master.
package tospc_pkg;

    localparam int CLK_NS = 20;
    localparam int PWM_TICK_NS = 50000;
    localparam logic [11:0] TICK_CYC = 12'(PWM_TICK_NS / CLK_NS);

    // Register and word addresses
    localparam logic [7:0] ADDR_CFG1 = 8'h03;
    localparam logic [7:0] ADDR_CFG0 = 8'h04;
    localparam logic [7:0] ADDR_OBJ = 8'h09;
    localparam logic [7:0] ADDR_AMB = 8'h0A;
    localparam logic [7:0] ADDR_THC1 = 8'h73;
    localparam logic [7:0] ADDR_HSC1 = 8'h74;
    localparam logic [7:0] ADDR_THREL = 8'h75;
    localparam logic [7:0] ADDR_HSREL = 8'h76;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Stored threshold and hysteresis data field
    localparam int WORD_DHI = 15;
    localparam int WORD_DLO = 5;

    // Configuration bit positions
    localparam int CFG1_EXT_THR = 12;
    localparam int CFG1_C1_SRC = 11;
    localparam int CFG1_C1_POL = 10;
    localparam int CFG1_REL_SRC = 8;
    localparam int CFG1_REL_POL = 7;
    localparam int CFG1_C1_EN = 6;
    localparam int CFG1_REL_EN = 5;
    localparam int CFG0_PWM_SRC = 15;
    localparam int CFG0_INC = 11;
    localparam int CFG0_DEC = 10;
    localparam int CFG0_SLOPE = 9;

    localparam logic [11:0] RES_MAX = 12'hFFF;
    localparam logic [11:0] RES_MIN = 12'h000;

    // PWM frame marks, in 50 us ticks
    localparam logic [11:0] PWM_LAST = 12'h7FF;
    localparam logic [11:0] PWM_LEAD = 12'h080;
    localparam logic [11:0] PWM_DATA_END = 12'h480;
    localparam logic [11:0] OVH_MARK = 12'h580;
    localparam logic [11:0] OVL_MARK = 12'h600;
    localparam logic [11:0] FE_MARK = 12'h680;
    localparam logic [11:0] NO_MARK = 12'h000;

    // Serial frame
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam logic [5:0] HDR_BITS = 6'h10;
    localparam logic [5:0] ECHO_DLY = 6'h08;

    // Opcode mask and match pairs
    localparam logic [7:0] RWR_M = 8'h74, RWR_V = 8'h50;
    localparam logic [7:0] RRD_M = 8'h7C, RRD_V = 8'h48;
    localparam logic [7:0] NWR_M = 8'hF0, NWR_V = 8'h10;
    localparam logic [7:0] NER_M = 8'hE0, NER_V = 8'h20;
    localparam logic [7:0] NRD_M = 8'h78, NRD_V = 8'h08;
    localparam logic [7:0] BWR_M = 8'hF0, BWR_V = 8'h90;
    localparam logic [7:0] BER_M = 8'hE0, BER_V = 8'hA0;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_REG_WR = 3'h1,
        CMD_REG_RD = 3'h2,
        CMD_NVM_WR = 3'h3,
        CMD_NVM_ER = 3'h4,
        CMD_NVM_RD = 3'h5,
        CMD_BLK_WR = 3'h6,
        CMD_BLK_ER = 3'h7
    } tospc_cmd_t;

endpackage

// ---- rtl/tospc_top.sv ----
// Result registers, comparators, PWM framer and serial slave.
// Assumes the sequencer drives results on core_clk and the master
// keeps the serial clock period at 160 ns or more.
`timescale 1ns/10ps
module tospc_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic result_valid,
    input wire logic [11:0] ambient_value,
    input wire logic [11:0] object_value,
    input wire logic ambient_over,
    input wire logic ambient_under,
    input wire logic ecc_double_err,
    input wire logic [11:0] ir_channel_sample,
    output logic sensor_slope_select,
    output logic curvature_decrease_sel,
    output logic curvature_increase_sel,
    output logic first_comparator,
    output logic relay_comparator,
    output logic pwm_out,
    output logic nvm_req,
    output logic [2:0] nvm_op,
    output logic [7:0] nvm_addr,
    output logic [15:0] nvm_wdata
);

    function automatic tospc_pkg::tospc_cmd_t decode(input logic [7:0] op);
        tospc_pkg::tospc_cmd_t k;
        k = tospc_pkg::CMD_NONE;
        if ((op & tospc_pkg::RWR_M) == tospc_pkg::RWR_V) begin
            k = tospc_pkg::CMD_REG_WR;
        end else if ((op & tospc_pkg::RRD_M) == tospc_pkg::RRD_V) begin
            k = tospc_pkg::CMD_REG_RD;
        end else if ((op & tospc_pkg::NWR_M) == tospc_pkg::NWR_V) begin
            k = tospc_pkg::CMD_NVM_WR;
        end else if ((op & tospc_pkg::NER_M) == tospc_pkg::NER_V) begin
            k = tospc_pkg::CMD_NVM_ER;
        end else if ((op & tospc_pkg::NRD_M) == tospc_pkg::NRD_V) begin
            k = tospc_pkg::CMD_NVM_RD;
        end else if ((op & tospc_pkg::BWR_M) == tospc_pkg::BWR_V) begin
            k = tospc_pkg::CMD_BLK_WR;
        end else if ((op & tospc_pkg::BER_M) == tospc_pkg::BER_V) begin
            k = tospc_pkg::CMD_BLK_ER;
        end
        return k;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return decode(op) == tospc_pkg::CMD_REG_RD ||
               decode(op) == tospc_pkg::CMD_NVM_RD;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Serial clock domain

    logic [5:0] bit_cnt;
    logic [31:0] rx;
    logic hdr_done;
    logic cmd_done;
    logic [31:0] cmd_word;
    logic [15:0] hdr_word;
    logic [15:0] rd_word;
    logic [15:0] rd_shift;
    logic rd_mode;

    // Frame counter cleared while select is high
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt <= 6'h00;
            hdr_done <= 1'b0;
            cmd_done <= 1'b0;
            rx <= 32'h0000_0000;
        end else if (bit_cnt != tospc_pkg::CMD_BITS) begin
            bit_cnt <= bit_cnt + 6'h01;
            rx <= {rx[30:0], spi_sdi};
            if (bit_cnt == tospc_pkg::HDR_BITS - 6'h01) begin
                hdr_done <= 1'b1;
            end
            // Early select release never reaches this
            if (bit_cnt == tospc_pkg::CMD_BITS - 6'h01) begin
                cmd_done <= 1'b1;
            end
        end
    end

    // Words held stable until the same point of the next frame
    always_ff @(posedge spi_sclk) begin
        if (bit_cnt == tospc_pkg::HDR_BITS - 6'h01) begin
            hdr_word <= {rx[14:0], spi_sdi};
        end
        if (bit_cnt == tospc_pkg::CMD_BITS - 6'h01) begin
            cmd_word <= {rx[30:0], spi_sdi};
        end
    end

    // Output changes on falling edges, valid at the next rising edge
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
            rd_shift <= 16'h0000;
            rd_mode <= 1'b0;
        end else begin
            spi_sdo_oe <= 1'b1;
            if (bit_cnt == tospc_pkg::HDR_BITS && is_read(rx[15:8])) begin
                rd_mode <= 1'b1;
                spi_sdo <= rd_word[15];
                rd_shift <= {rd_word[14:0], 1'b0};
            end else if (rd_mode) begin
                spi_sdo <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
            end else if (bit_cnt >= tospc_pkg::ECHO_DLY) begin
                spi_sdo <= rx[7];
            end else begin
                spi_sdo <= 1'b0;
            end
        end
    end

    chk_echo_delay: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n)
        (bit_cnt >= 6'h09 && bit_cnt <= 6'h10 && !rd_mode)
        |-> spi_sdo == rx[7])
        else $error("echo not eight clocks late");

    ////////////////////////////////////////////////////////////////////
    // Crossing into the core domain

    logic [2:0] hdr_sync;
    logic [2:0] cmd_sync;
    logic hdr_rise;
    logic cmd_rise;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hdr_sync <= 3'h0;
            cmd_sync <= 3'h0;
        end else begin
            hdr_sync <= {hdr_sync[1:0], hdr_done};
            cmd_sync <= {cmd_sync[1:0], cmd_done};
        end
    end

    assign hdr_rise = hdr_sync[1] & ~hdr_sync[2];
    assign cmd_rise = cmd_sync[1] & ~cmd_sync[2];

    ////////////////////////////////////////////////////////////////////
    // Results and status

    logic [11:0] amb_res;
    logic [11:0] obj_res;
    logic st_over;
    logic st_under;
    logic st_fatal;
    logic [3:0] status;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            amb_res <= tospc_pkg::RES_MIN;
            obj_res <= tospc_pkg::RES_MIN;
            st_over <= 1'b0;
            st_under <= 1'b0;
        end else if (result_valid) begin
            st_over <= ambient_over;
            st_under <= ambient_under & ~ambient_over;
            if (ambient_over) begin
                amb_res <= tospc_pkg::RES_MAX;
                obj_res <= tospc_pkg::RES_MAX;
            end else if (ambient_under) begin
                amb_res <= tospc_pkg::RES_MIN;
                obj_res <= tospc_pkg::RES_MIN;
            end else begin
                amb_res <= ambient_value;
                obj_res <= object_value;
            end
        end
    end

    // Sticky until reset; data itself is not touched here
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_fatal <= 1'b0;
        end else if (ecc_double_err) begin
            st_fatal <= 1'b1;
        end
    end

    assign status = {st_over, st_under, st_fatal, 1'b0};

    chk_over_clamp: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (result_valid && ambient_over) |=> amb_res == 12'hFFF &&
        obj_res == 12'hFFF && status[3])
        else $error("overflow did not clamp both results");
    chk_under_clamp: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (result_valid && ambient_under && !ambient_over) |=>
        amb_res == 12'h000 && obj_res == 12'h000 && status[2])
        else $error("underflow did not clamp both results");
    chk_fatal_sticky: assert property (@(posedge core_clk)
        disable iff (!nrst)
        ecc_double_err |=> status[1] [*8])
        else $error("fatal flag not held");

    ////////////////////////////////////////////////////////////////////
    // Registers and command execution

    logic [15:0] cfg1;
    logic [15:0] cfg0;
    logic [15:0] w_thc1;
    logic [15:0] w_hsc1;
    logic [15:0] w_threl;
    logic [15:0] w_hsrel;
    tospc_pkg::tospc_cmd_t cmd_kind;
    logic [7:0] cmd_addr;
    logic [15:0] cmd_data;
    logic shadow_wr;

    assign cmd_kind = decode(cmd_word[31:24]);
    assign cmd_addr = cmd_word[23:16];
    assign cmd_data = cmd_word[15:0];
    assign shadow_wr = cmd_rise && (cmd_kind == tospc_pkg::CMD_REG_WR ||
                                    cmd_kind == tospc_pkg::CMD_NVM_WR);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg1 <= tospc_pkg::CFG_RESET;
            cfg0 <= tospc_pkg::CFG_RESET;
            w_thc1 <= tospc_pkg::WORD_RESET;
            w_hsc1 <= tospc_pkg::WORD_RESET;
            w_threl <= tospc_pkg::WORD_RESET;
            w_hsrel <= tospc_pkg::WORD_RESET;
        end else if (shadow_wr) begin
            case (cmd_addr)
                tospc_pkg::ADDR_CFG1: cfg1 <= cmd_data;
                tospc_pkg::ADDR_CFG0: cfg0 <= cmd_data;
                tospc_pkg::ADDR_THC1: w_thc1 <= cmd_data;
                tospc_pkg::ADDR_HSC1: w_hsc1 <= cmd_data;
                tospc_pkg::ADDR_THREL: w_threl <= cmd_data;
                tospc_pkg::ADDR_HSREL: w_hsrel <= cmd_data;
                default: cfg1 <= cfg1;
            endcase
        end
    end

    // Memory write and erase commands go out as one strobe; memory reads raise none
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            nvm_req <= 1'b0;
            nvm_op <= tospc_pkg::CMD_NONE;
            nvm_addr <= 8'h00;
            nvm_wdata <= 16'h0000;
        end else begin
            nvm_req <= cmd_rise && cmd_kind != tospc_pkg::CMD_NONE &&
                       cmd_kind != tospc_pkg::CMD_REG_WR &&
                       cmd_kind != tospc_pkg::CMD_REG_RD &&
                       cmd_kind != tospc_pkg::CMD_NVM_RD;
            if (cmd_rise) begin
                nvm_op <= cmd_kind;
                nvm_addr <= cmd_addr;
                nvm_wdata <= cmd_data;
            end
        end
    end

    // Read word loaded on the third core clock after the header completes, before the falling edge that shifts it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_word <= 16'h0000;
        end else if (hdr_rise) begin
            case (hdr_word[7:0])
                tospc_pkg::ADDR_OBJ: rd_word <= {obj_res, status};
                tospc_pkg::ADDR_AMB: rd_word <= {amb_res, status};
                tospc_pkg::ADDR_CFG1: rd_word <= cfg1;
                tospc_pkg::ADDR_CFG0: rd_word <= cfg0;
                tospc_pkg::ADDR_THC1: rd_word <= w_thc1;
                tospc_pkg::ADDR_HSC1: rd_word <= w_hsc1;
                tospc_pkg::ADDR_THREL: rd_word <= w_threl;
                tospc_pkg::ADDR_HSREL: rd_word <= w_hsrel;
                default: rd_word <= 16'h0000;
            endcase
        end
    end

    chk_read_word: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (hdr_rise && hdr_word[7:0] == 8'h0A) |=>
        rd_word == $past({amb_res, status}))
        else $error("ambient read word wrong");

    assign sensor_slope_select = cfg0[tospc_pkg::CFG0_SLOPE];
    assign curvature_decrease_sel = cfg0[tospc_pkg::CFG0_DEC];
    assign curvature_increase_sel = cfg0[tospc_pkg::CFG0_INC];

    ////////////////////////////////////////////////////////////////////
    // Comparators

    logic cmp_start;
    logic [11:0] cmp_val [2];
    logic [11:0] cmp_thr [2];
    logic [11:0] cmp_hys [2];
    logic [1:0] cmp_src;
    logic [1:0] cmp_pol;
    logic [1:0] cmp_en;
    logic [1:0] cmp_hit;
    logic [1:0] cmp_out;

    assign cmp_src = {cfg1[tospc_pkg::CFG1_REL_SRC],
                      cfg1[tospc_pkg::CFG1_C1_SRC]};
    assign cmp_pol = {cfg1[tospc_pkg::CFG1_REL_POL],
                      cfg1[tospc_pkg::CFG1_C1_POL]};
    assign cmp_en = {cfg1[tospc_pkg::CFG1_REL_EN],
                     cfg1[tospc_pkg::CFG1_C1_EN]};
    assign cmp_thr[0] = {w_thc1[tospc_pkg::WORD_DHI:tospc_pkg::WORD_DLO],
                         1'b0};
    assign cmp_thr[1] = cfg1[tospc_pkg::CFG1_EXT_THR] ? ir_channel_sample :
                        {w_threl[tospc_pkg::WORD_DHI:tospc_pkg::WORD_DLO],
                         1'b0};
    assign cmp_hys[0] = {w_hsc1[tospc_pkg::WORD_DHI:tospc_pkg::WORD_DLO],
                         1'b0};
    assign cmp_hys[1] = {w_hsrel[tospc_pkg::WORD_DHI:tospc_pkg::WORD_DLO],
                         1'b0};

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cmp_start <= 1'b0;
        end else begin
            cmp_start <= result_valid && (cmp_en != 2'h0);
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_cmp
        logic [11:0] low_lim;
        assign cmp_val[g] = cmp_src[g] ? amb_res : obj_res;
        assign low_lim = (cmp_thr[g] > cmp_hys[g]) ?
                         cmp_thr[g] - cmp_hys[g] : 12'h000;
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                cmp_hit[g] <= 1'b0;
            end else if (cmp_start && cmp_en[g]) begin
                if (cmp_val[g] >= cmp_thr[g]) begin
                    cmp_hit[g] <= 1'b1;
                end else if (cmp_val[g] < low_lim) begin
                    cmp_hit[g] <= 1'b0;
                end
            end
        end
        // Polarity 0 inverts
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                cmp_out[g] <= 1'b0;
            end else begin
                cmp_out[g] <= cmp_hit[g] ^ ~cmp_pol[g];
            end
        end
    end

    assign first_comparator = cmp_out[0];
    assign relay_comparator = cmp_out[1];

    chk_cmp_gated: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cmp_start |-> $past(result_valid) && cmp_en != 2'h0)
        else $error("comparators started without update");
    chk_relay_src: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (cmp_start && cmp_en[1] && cfg1[tospc_pkg::CFG1_EXT_THR] &&
        cmp_val[1] >= ir_channel_sample) |=> cmp_hit[1])
        else $error("relay ignored external threshold");

    ////////////////////////////////////////////////////////////////////
    // PWM framer

    logic [11:0] tick_div;
    logic tick;
    logic [11:0] pwm_cnt;
    logic [9:0] fr_val;
    logic [11:0] fr_mark;
    logic [11:0] data_pos;
    logic next_pwm;

    assign tick = tick_div == tospc_pkg::TICK_CYC - 12'h001;

    always_ff @(posedge core_clk) begin
        if (!nrst || tick) begin
            tick_div <= 12'h000;
        end else begin
            tick_div <= tick_div + 12'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pwm_cnt <= 12'h000;
        end else if (tick) begin
            pwm_cnt <= (pwm_cnt == tospc_pkg::PWM_LAST) ?
                       12'h000 : pwm_cnt + 12'h001;
        end
    end

    // Value and condition frozen for the whole frame
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fr_val <= 10'h000;
            fr_mark <= tospc_pkg::NO_MARK;
        end else if (tick && pwm_cnt == tospc_pkg::PWM_LAST) begin
            fr_val <= cfg0[tospc_pkg::CFG0_PWM_SRC] ? amb_res[11:2] :
                      obj_res[11:2];
            if (st_over) begin
                fr_mark <= tospc_pkg::OVH_MARK;
            end else if (st_under) begin
                fr_mark <= tospc_pkg::OVL_MARK;
            end else if (st_fatal) begin
                fr_mark <= tospc_pkg::FE_MARK;
            end else begin
                fr_mark <= tospc_pkg::NO_MARK;
            end
        end
    end

    assign data_pos = pwm_cnt - tospc_pkg::PWM_LEAD;

    always_comb begin
        next_pwm = 1'b0;
        if (fr_mark != tospc_pkg::NO_MARK) begin
            next_pwm = pwm_cnt < fr_mark;
        end else if (pwm_cnt < tospc_pkg::PWM_LEAD) begin
            next_pwm = 1'b1;
        end else if (pwm_cnt < tospc_pkg::PWM_DATA_END) begin
            next_pwm = data_pos < {2'h0, fr_val};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= next_pwm;
        end
    end

    chk_pwm_wrap: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (tick && pwm_cnt == 12'h7FF) |=> pwm_cnt == 12'h000)
        else $error("frame not 2048 ticks");
    chk_pwm_lead: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (pwm_cnt < 12'h080) |=> pwm_out)
        else $error("lead interval not high");
    chk_ovh_band: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (fr_mark == 12'h580 && pwm_cnt >= 12'h580) |=> !pwm_out)
        else $error("overflow band too long");

    cov_read_frame: cover property (@(posedge core_clk)
        disable iff (!nrst) hdr_rise && is_read(hdr_word[15:8]));
    cov_reg_write: cover property (@(posedge core_clk)
        disable iff (!nrst) cmd_rise && cmd_kind == tospc_pkg::CMD_REG_WR);
    cov_relay_hit: cover property (@(posedge core_clk)
        disable iff (!nrst) $rose(cmp_hit[1]));
    cov_fe_frame: cover property (@(posedge core_clk)
        disable iff (!nrst) fr_mark == tospc_pkg::FE_MARK);

endmodule

// ---- verif/tospc_spi_master.sv ----
// Serial master model for the link pins of the output block.
// Assumes one caller at a time; sclk stands low outside frames.
`timescale 1ns/10ps
module tospc_spi_master (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // Frame of n bits, MSB first; sdo sampled on each rising edge
    task automatic xfer(input logic [31:0] cmd, input int n,
            output logic [31:0] rx);
        rx = 32'h0000_0000;
        #7;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = cmd[31 - i];
            #80 sclk = 1'b1;
            rx[31 - i] = sdo;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        sdi = ~sdi;
        #200;
    endtask
endmodule

// ---- verif/tospc_tb_top.sv ----
// Self-checking bench for the output block.
// Assumes the serial master model drives the link pins.
`timescale 1ns/10ps
module tospc_tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic result_valid = 1'b0;
    logic ambient_over = 1'b0;
    logic ambient_under = 1'b0;
    logic ecc_double_err = 1'b0;
    logic [11:0] ambient_value = 12'h000;
    logic [11:0] object_value = 12'h000;
    logic [11:0] ir_channel_sample = 12'h000;
    logic sclk, cs_n, sdi, sdo, slope, dec, inc, c1, rel, pwm, req;
    logic [2:0] op;
    logic [7:0] ad;
    logic oe;
    logic [15:0] wd;
    logic [31:0] seed = 32'h0000_000A;
    logic [7:0] rdops [4] = '{8'h48, 8'hCB, 8'h08, 8'h8F};
    logic [7:0] nvops [4] = '{8'h10, 8'h20, 8'h90, 8'hA0};
    logic [2:0] nvexp [4] = '{3'h3, 3'h4, 3'h6, 3'h7};
    logic [11:0] amb [3] = '{12'h401, 12'h3FF, 12'h3BF};
    int n_errors = 0;
    int samples_checked = 0;
    int n_req = 0;

    tospc_spi_master master (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo));
    tospc_top dut (.core_clk(core_clk), .nrst(nrst), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe),
        .result_valid(result_valid), .ambient_value(ambient_value),
        .object_value(object_value), .ambient_over(ambient_over),
        .ambient_under(ambient_under), .ecc_double_err(ecc_double_err),
        .ir_channel_sample(ir_channel_sample),
        .sensor_slope_select(slope), .curvature_decrease_sel(dec),
        .curvature_increase_sel(inc), .first_comparator(c1),
        .relay_comparator(rel), .pwm_out(pwm), .nvm_req(req),
        .nvm_op(op), .nvm_addr(ad), .nvm_wdata(wd));

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (req === 1'b1) n_req++;
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] res(input logic [11:0] v,
            input logic o, u, f);
        return {o ? 12'hFFF : (u ? 12'h000 : v), o, u, f, 1'b0};
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic put(input logic [11:0] a, b, input logic o, u);
        seed = xs(seed);
        @(posedge core_clk);
        result_valid <= 1'b1;
        ambient_value <= a;
        object_value <= b;
        ambient_over <= o;
        ambient_under <= u;
        ir_channel_sample <= seed[11:0];
        @(posedge core_clk);
        result_valid <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] c, a, input logic [15:0] ex);
        logic [31:0] rx;
        master.xfer({c, a, 16'h0000}, 32, rx);
        check("read data", rx[15:0], ex);
        check("read opcode echo", rx[23:16], c);
    endtask
    task automatic wr(input logic [7:0] c, a, input logic [15:0] d,
            input int n);
        logic [31:0] rx;
        master.xfer({c, a, d}, n, rx);
        if (n == 32) check("write echo", rx[23:0], {c, a, d[15:8]});
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("pwm lead", pwm, 1'b1);
        for (int i = 0; i < 8; i++) begin
            put(seed[11:0], seed[27:16], 1'b0, 1'b0);
            rd(rdops[i % 4], 8'h0A, res(ambient_value, 0, 0, 0));
            rd(rdops[3 - i % 4], 8'h09, res(object_value, 0, 0, 0));
        end
        put(12'h123, 12'h456, 1'b1, 1'b0);
        rd(8'h48, 8'h0A, 16'hFFF8);
        rd(8'h48, 8'h09, 16'hFFF8);
        put(12'h123, 12'h456, 1'b0, 1'b1);
        rd(8'h48, 8'h0A, 16'h0004);
        rd(8'h48, 8'h09, 16'h0004);
        rd(8'h48, 8'h05, 16'h0000);
        wr(8'h50, 8'h04, 16'h0E00, 32);
        check("curve bits", {inc, dec, slope}, 3'h7);
        wr(8'hD3, 8'h04, 16'h0200, 20);
        rd(8'h48, 8'h04, 16'h0E00);
        wr(8'hD3, 8'h04, 16'h0200, 32);
        check("curve bits", {inc, dec, slope}, 3'h1);
        for (int i = 0; i < 4; i++) begin
            wr(nvops[i], 8'h78, 16'h1234, 32);
            check("nvm op", op, nvexp[i]);
            check("nvm addr", ad, 8'h78);
            check("nvm data", wd, 16'h1234);
        end
        check("nvm pulses", n_req, 4);
        check("sdo idle", {oe, sdo}, 2'h0);
        wr(8'h50, 8'h73, 16'h4000, 32);
        wr(8'h50, 8'h75, 16'h4000, 32);
        wr(8'h50, 8'h74, 16'h0400, 32);
        wr(8'h50, 8'h76, 16'h0400, 32);
        wr(8'h50, 8'h03, 16'h0DE0, 32);
        for (int i = 0; i < 3; i++) begin
            put(amb[i], 12'h000, 1'b0, 1'b0);
            check("first comparator", c1, i < 2);
            check("relay comparator", rel, i < 2);
        end
        wr(8'h50, 8'h03, 16'h1DE0, 32);
        put(12'hFFF, 12'h000, 1'b0, 1'b0);
        check("relay external", rel, 1'b1);
        put(12'h000, 12'h000, 1'b0, 1'b0);
        check("first comparator", c1, 1'b0);
        check("relay external", rel, ir_channel_sample <= 12'h040);
        @(posedge core_clk);
        ecc_double_err <= 1'b1;
        @(posedge core_clk);
        ecc_double_err <= 1'b0;
        put(12'h0AB, 12'h0CD, 1'b0, 1'b0);
        rd(8'h48, 8'h0A, 16'h0AB2);
        rd(8'h48, 8'h09, 16'h0CD2);
        wrap_up();
    end
endmodule
